// File: supply_regs_pkg.sv
// Operation
// - linear regulator on states live in bits 9,8
// - undervoltage and wake flags latch, clear on write-1
// - wake pin live levels in bits 3,2
// - live bit reads pin level after two sync flops
// - wake source flags bits 1,0, write-1 clears
// - monitor assignment codes select internal rails
// - codes 000,110,111 mean external regulator
// - read-only scaling offset, 6.25 mV steps
// - scratch stores and returns any 16-bit value
// - scratch split in two bytes, reset zero
`default_nettype none
package supply_regs_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [1:0] ADDR_FLAGS_TWO = 2'h0;
  localparam logic [1:0] ADDR_MON_ASSIGN = 2'h1;
  localparam logic [1:0] ADDR_BUCK_SCALING = 2'h2;
  localparam logic [1:0] ADDR_SCRATCH_ZERO = 2'h3;
  // ****************************************
  // field positions
  // ****************************************
  localparam int POS_LINEAR_A_ON = 9;
  localparam int POS_LINEAR_B_ON = 8;
  localparam int POS_PRE_UV_LOW = 7;
  localparam int POS_PRE_UV_HIGH = 6;
  localparam int POS_SUP_UV_LOW = 5;
  localparam int POS_SUP_UV_HIGH = 4;
  localparam int POS_WAKE_B_LIVE = 3;
  localparam int POS_WAKE_A_LIVE = 2;
  localparam int POS_WAKE_B_FLAG = 1;
  localparam int POS_WAKE_A_FLAG = 0;
  localparam int NUM_FLAGS = 6;
  localparam int MON_ASSIGN_W = 3;
  localparam int SCALING_W = 5;
  // ****************************************
  // reset values and codes
  // ****************************************
  localparam logic [5:0] FLAGS_RESET = 6'h00;
  localparam logic [2:0] MON_ASSIGN_RESET = 3'h0;
  localparam logic [15:0] SCRATCH_RESET = 16'h0000;
  localparam logic [4:0] SCALING_MAX = 5'h10;
  localparam logic [4:0] SCALING_RESET = 5'h00;
  localparam logic EXT_RESET = 1'b1;
  localparam logic [15:0] RDATA_RESET = 16'h0000;
  typedef enum logic [2:0] {
    MON_EXTERNAL = 3'h0,
    MON_PRE_REG = 3'h1,
    MON_LINEAR_A = 3'h2,
    MON_LINEAR_B = 3'h3,
    MON_SECOND_BUCK = 3'h4,
    MON_THIRD_BUCK = 3'h5
  } monitor_source_t;
endpackage : supply_regs_pkg
`default_nettype wire

// File: supply_status_config_regs.sv
`default_nettype none
module supply_status_config_regs (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic linear_a_on,
  input wire logic linear_b_on,
  input wire logic prereg_uv_low_evt,
  input wire logic prereg_uv_high_evt,
  input wire logic supply_uv_low_evt,
  input wire logic supply_uv_high_evt,
  input wire logic wake_pin_a,
  input wire logic wake_pin_b,
  input wire logic wake_a_source_evt,
  input wire logic wake_b_source_evt,
  input wire logic [4:0] core_buck_scaling_offset,
  output logic [2:0] monitor_a_assignment,
  output logic voltage_monitor_a_external
);
  // ****************************************
  // input synchronisers
  // ****************************************
  // every outside level passes two flops before any logic reads it
  localparam int NIN = 15;
  localparam int IDX_LINEAR_A = 0;
  localparam int IDX_LINEAR_B = 1;
  localparam int IDX_WAKE_A_PIN = 2;
  localparam int IDX_WAKE_B_PIN = 3;
  localparam int IDX_PRE_LOW = 4;
  localparam int IDX_PRE_HIGH = 5;
  localparam int IDX_SUP_LOW = 6;
  localparam int IDX_SUP_HIGH = 7;
  localparam int IDX_WAKE_A_SRC = 8;
  localparam int IDX_WAKE_B_SRC = 9;
  localparam int IDX_SCALING_LSB = 10;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sync1_r;
  logic [NIN-1:0] sync1_nxt;
  logic [NIN-1:0] sync2_r;
  logic [NIN-1:0] sync2_nxt;
  assign raw_in = {
    core_buck_scaling_offset,
    wake_b_source_evt,
    wake_a_source_evt,
    supply_uv_high_evt,
    supply_uv_low_evt,
    prereg_uv_high_evt,
    prereg_uv_low_evt,
    wake_pin_b,
    wake_pin_a,
    linear_b_on,
    linear_a_on
  };
  always_comb
  begin
    sync1_nxt = raw_in;
    sync2_nxt = sync1_r;
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end
  // ****************************************
  // synchronised levels
  // ****************************************
  logic linear_a_live;
  logic linear_b_live;
  logic wake_a_live;
  logic wake_b_live;
  logic [4:0] scaling_live;
  logic [5:0] evt;
  assign linear_a_live = sync2_r[IDX_LINEAR_A];
  assign linear_b_live = sync2_r[IDX_LINEAR_B];
  assign wake_a_live = sync2_r[IDX_WAKE_A_PIN];
  assign wake_b_live = sync2_r[IDX_WAKE_B_PIN];
  assign scaling_live = sync2_r[IDX_SCALING_LSB +: supply_regs_pkg::SCALING_W];
  // flag order, msb first: pre low, pre high, sup low, sup high, wake b, wake a
  assign evt = {
    sync2_r[IDX_PRE_LOW],
    sync2_r[IDX_PRE_HIGH],
    sync2_r[IDX_SUP_LOW],
    sync2_r[IDX_SUP_HIGH],
    sync2_r[IDX_WAKE_B_SRC],
    sync2_r[IDX_WAKE_A_SRC]
  };
  // ****************************************
  // scaling offset capture
  // ****************************************
  // the offset bits cross one by one; a word is taken only when two
  // samples in a row agree, so a half-changed code never reaches the host
  logic [4:0] scaling_prev_r;
  logic [4:0] scaling_prev_nxt;
  logic [4:0] scaling_r;
  logic [4:0] scaling_nxt;
  always_comb
  begin
    scaling_prev_nxt = scaling_live;
    scaling_nxt = scaling_r;
    if (scaling_live == scaling_prev_r)
    begin
      scaling_nxt = scaling_live;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      scaling_prev_r <= supply_regs_pkg::SCALING_RESET;
      scaling_r <= supply_regs_pkg::SCALING_RESET;
    end
    else
    begin
      scaling_prev_r <= scaling_prev_nxt;
      scaling_r <= scaling_nxt;
    end
  end
  // ****************************************
  // event flags
  // ****************************************
  logic [5:0] flags_r;
  logic [5:0] flags_nxt;
  logic [5:0] clr;
  logic flag_write;
  always_comb
  begin
    flag_write = reg_wr && (reg_addr == supply_regs_pkg::ADDR_FLAGS_TWO);
    clr = '0;
    if (flag_write)
    begin
      // live bits have no clear path, so writes cannot touch them
      clr[5] = reg_wdata[supply_regs_pkg::POS_PRE_UV_LOW];
      clr[4] = reg_wdata[supply_regs_pkg::POS_PRE_UV_HIGH];
      clr[3] = reg_wdata[supply_regs_pkg::POS_SUP_UV_LOW];
      clr[2] = reg_wdata[supply_regs_pkg::POS_SUP_UV_HIGH];
      clr[1] = reg_wdata[supply_regs_pkg::POS_WAKE_B_FLAG];
      clr[0] = reg_wdata[supply_regs_pkg::POS_WAKE_A_FLAG];
    end
  end
  // an event that lands with its clear keeps the flag set, so it is never lost
  for (genvar gi = 0; gi < supply_regs_pkg::NUM_FLAGS; gi++)
  begin : g_flag
    assign flags_nxt[gi] = evt[gi] | (flags_r[gi] & ~clr[gi]);
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      flags_r <= supply_regs_pkg::FLAGS_RESET;
    end
    else
    begin
      flags_r <= flags_nxt;
    end
  end
  // ****************************************
  // monitor assignment
  // ****************************************
  logic [2:0] mon_r;
  logic [2:0] mon_nxt;
  logic mon_write;
  always_comb
  begin
    mon_write = reg_wr && (reg_addr == supply_regs_pkg::ADDR_MON_ASSIGN);
    mon_nxt = mon_r;
    if (mon_write)
    begin
      // upper data bits are reserved and dropped here
      mon_nxt = reg_wdata[supply_regs_pkg::MON_ASSIGN_W-1:0];
    end
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      mon_r <= supply_regs_pkg::MON_ASSIGN_RESET;
    end
    else
    begin
      mon_r <= mon_nxt;
    end
  end
  // ****************************************
  // scratch word
  // ****************************************
  logic [15:0] scratch_r;
  logic [15:0] scratch_nxt;
  logic scratch_write;
  always_comb
  begin
    scratch_write = reg_wr && (reg_addr == supply_regs_pkg::ADDR_SCRATCH_ZERO);
    scratch_nxt = scratch_r;
    if (scratch_write)
    begin
      scratch_nxt[15:8] = reg_wdata[15:8]; // upper byte
      scratch_nxt[7:0] = reg_wdata[7:0]; // lower byte
    end
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      scratch_r <= supply_regs_pkg::SCRATCH_RESET;
    end
    else
    begin
      scratch_r <= scratch_nxt;
    end
  end
  // ****************************************
  // read data
  // ****************************************
  // the scaling register has no write path, so writes there are ignored
  logic [15:0] live_word;
  logic [15:0] rdata_nxt;
  always_comb
  begin
    live_word = 16'h0000;
    live_word[supply_regs_pkg::POS_LINEAR_A_ON] = linear_a_live;
    live_word[supply_regs_pkg::POS_LINEAR_B_ON] = linear_b_live;
    live_word[supply_regs_pkg::POS_PRE_UV_LOW] = flags_r[5];
    live_word[supply_regs_pkg::POS_PRE_UV_HIGH] = flags_r[4];
    live_word[supply_regs_pkg::POS_SUP_UV_LOW] = flags_r[3];
    live_word[supply_regs_pkg::POS_SUP_UV_HIGH] = flags_r[2];
    live_word[supply_regs_pkg::POS_WAKE_B_LIVE] = wake_b_live;
    live_word[supply_regs_pkg::POS_WAKE_A_LIVE] = wake_a_live;
    live_word[supply_regs_pkg::POS_WAKE_B_FLAG] = flags_r[1];
    live_word[supply_regs_pkg::POS_WAKE_A_FLAG] = flags_r[0];
    unique case (reg_addr)
      supply_regs_pkg::ADDR_FLAGS_TWO:
      begin
        rdata_nxt = live_word;
      end
      supply_regs_pkg::ADDR_MON_ASSIGN:
      begin
        rdata_nxt = {13'h0, mon_r};
      end
      supply_regs_pkg::ADDR_BUCK_SCALING:
      begin
        rdata_nxt = {11'h0, scaling_r};
      end
      supply_regs_pkg::ADDR_SCRATCH_ZERO:
      begin
        rdata_nxt = scratch_r;
      end
    endcase
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= supply_regs_pkg::RDATA_RESET;
    end
    else
    begin
      reg_rdata <= rdata_nxt;
    end
  end
  // ****************************************
  // monitor routing outputs
  // ****************************************
  logic [2:0] mon_out_nxt;
  logic ext_nxt;
  always_comb
  begin
    mon_out_nxt = mon_r;
    unique case (mon_r)
      supply_regs_pkg::MON_EXTERNAL:
      begin
        ext_nxt = 1'b1;
      end
      supply_regs_pkg::MON_PRE_REG,
      supply_regs_pkg::MON_LINEAR_A,
      supply_regs_pkg::MON_LINEAR_B,
      supply_regs_pkg::MON_SECOND_BUCK,
      supply_regs_pkg::MON_THIRD_BUCK:
      begin
        ext_nxt = 1'b0;
      end
      3'h6,
      3'h7:
      begin
        // both spare codes fall back to an outside regulator
        ext_nxt = 1'b1;
      end
    endcase
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      monitor_a_assignment <= supply_regs_pkg::MON_ASSIGN_RESET;
      voltage_monitor_a_external <= supply_regs_pkg::EXT_RESET;
    end
    else
    begin
      monitor_a_assignment <= mon_out_nxt;
      voltage_monitor_a_external <= ext_nxt;
    end
  end
endmodule : supply_status_config_regs
`default_nettype wire

// File: supply_regs_props.sv
`default_nettype none
module supply_regs_props (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic wake_pin_a,
  input wire logic voltage_monitor_a_external,
  input wire logic [1:0] reg_addr,
  input wire logic [2:0] monitor_a_assignment,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_EXT: assert property (voltage_monitor_a_external ==
    (monitor_a_assignment inside {3'h0, 3'h6, 3'h7})) else $error("ext flag wrong");
  AST_MON: assert property (reg_wr && reg_addr == 2'h1 |-> ##3
    monitor_a_assignment == $past(reg_wdata[2:0], 3)) else $error("monitor code lost");
  AST_SCR: assert property (reg_wr && reg_addr == 2'h3 ##1 !reg_wr && reg_addr == 2'h3
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("scratch readback");
  AST_RES1: assert property ($past(reg_addr) == 2'h1 |-> reg_rdata[15:3] == 13'h0000)
    else $error("monitor reserved");
  AST_RES2: assert property ($past(reg_addr) == 2'h2 |-> reg_rdata[15:5] == 11'h000)
    else $error("scaling reserved");
  AST_RES0: assert property ($past(reg_addr) == 2'h0 |-> reg_rdata[15:10] == 6'h00)
    else $error("flags reserved");
  AST_WKH: assert property ((wake_pin_a && reg_addr == 2'h0) [*6] |-> reg_rdata[2])
    else $error("wake high");
  AST_WKL: assert property ((!wake_pin_a && reg_addr == 2'h0) [*6] |-> !reg_rdata[2])
    else $error("wake low");
  cover property (reg_wr && reg_addr == 2'h3);
  cover property (reg_wr && reg_addr == 2'h2);
  cover property (voltage_monitor_a_external && reg_wr);
endmodule : supply_regs_props
bind supply_status_config_regs supply_regs_props u_props (.mclk(mclk), .rst_n(rst_n),
  .reg_wr(reg_wr), .wake_pin_a(wake_pin_a), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .voltage_monitor_a_external(voltage_monitor_a_external), .reg_rdata(reg_rdata),
  .monitor_a_assignment(monitor_a_assignment));
`default_nettype wire

// File: host_link_model.sv
`default_nettype none
module host_link_model (
  input wire logic mclk,
  output var logic [1:0] reg_addr = 2'h0,
  output var logic reg_wr = 1'b0,
  output var logic [15:0] reg_wdata = 16'h0000,
  input wire logic [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // released data shows the inverse so a stale value cannot pass
  task wr(input logic [1:0] a, input logic [15:0] d);
    @(negedge mclk);
    {reg_addr, reg_wr, reg_wdata} = {a, 1'b1, d};
    @(negedge mclk);
    {reg_wr, reg_wdata} = {1'b0, ~d};
  endtask : wr
  task rd(input logic [1:0] a, output logic [15:0] d);
    @(negedge mclk);
    reg_addr = a;
    repeat (2) @(negedge mclk);
    d = reg_rdata;
  endtask : rd
endmodule : host_link_model
`default_nettype wire

// File: test_supply_status_config_regs.sv
`default_nettype none
module test_supply_status_config_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, rst_n = 0, ext, la = 0, lb = 0, sl = 0, wa = 0, wb = 0, ea = 0;
  logic [1:0] a;
  logic wr;
  logic [2:0] mon;
  logic [4:0] sc = 5'h00;
  logic [15:0] wd, rdat, d;
  int n_errors = 0, checked = 0;
  always #12.5 mclk = ~mclk;
  host_link_model u_host (.mclk(mclk), .reg_addr(a), .reg_wr(wr), .reg_wdata(wd),
    .reg_rdata(rdat));
  supply_status_config_regs u_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(a), .reg_wr(wr),
    .reg_wdata(wd), .reg_rdata(rdat), .linear_a_on(la), .linear_b_on(lb), .prereg_uv_low_evt(sl),
    .prereg_uv_high_evt(ea), .supply_uv_low_evt(sl), .supply_uv_high_evt(ea), .wake_pin_a(wa),
    .wake_pin_b(wb), .wake_a_source_evt(ea), .wake_b_source_evt(sl),
    .core_buck_scaling_offset(sc), .monitor_a_assignment(mon), .voltage_monitor_a_external(ext));
  task chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task print_verdict;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  initial
  begin
    #60000;
    n_errors++;
    print_verdict;
  end
  initial
  begin
    repeat (4) @(negedge mclk);
    rst_n = 1;
    u_host.rd(2'h3, d); chk(d, 16'h0000);
    {la, wb, sl, ea, sc} = {4'hF, 5'h10};
    repeat (5) @(negedge mclk);
    {sl, ea} = 2'h0;
    repeat (5) @(negedge mclk);
    u_host.rd(2'h0, d); chk(d, 16'h02FB);
    u_host.wr(2'h0, 16'h0000); u_host.rd(2'h0, d); chk(d, 16'h02FB);
    u_host.wr(2'h0, 16'h03FF); u_host.rd(2'h0, d); chk(d, 16'h0208);
    {wa, wb} = 2'h2;
    repeat (5) @(negedge mclk);
    u_host.rd(2'h0, d); chk(d, 16'h0204);
    u_host.wr(2'h2, 16'hFFFF); u_host.rd(2'h2, d); chk(d, 16'h0010);
    for (int i = 0; i < 8; i++)
    begin
      u_host.wr(2'h1, 16'hFFF8 | 16'(i)); u_host.rd(2'h1, d); chk(d, 16'(i));
      chk(ext, 16'(i == 0 || i > 5));
      chk(16'(mon), 16'(i));
    end
    u_host.wr(2'h3, 16'hA55A);
    u_host.wr(2'h3, 16'h5AA5);
    u_host.rd(2'h3, d);
    chk(d, 16'h5AA5);
    print_verdict;
  end
endmodule : test_supply_status_config_regs
`default_nettype wire
